// File: rffe_switch_pkg.sv
// Purpose: Shared constants for the serial-bus switch control register bank.
// Assumes: Link clock carries one frame bit per period, sampled on its falling edge.
// Notes:   Bit indices count from the first command bit after the start sequence.
package rffe_switch_pkg;

  localparam int unsigned DATA_W    = 8;
  localparam int unsigned ADDR_W    = 5;
  localparam int unsigned CMD_W     = 12;
  localparam int unsigned SID_W     = 4;
  localparam int unsigned CNT_W     = 5;
  localparam int unsigned NUM_TRIG  = 3;

  // Register addresses.
  localparam logic [ADDR_W-1:0] ADDR_PATH   = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_CTRL   = 5'h1C;
  localparam logic [ADDR_W-1:0] ADDR_PART   = 5'h1D;
  localparam logic [ADDR_W-1:0] ADDR_MAKERL = 5'h1E;
  localparam logic [ADDR_W-1:0] ADDR_MAKERH = 5'h1F;

  // Command frame fields.
  localparam int unsigned SA_HI       = 11;
  localparam int unsigned SA_LO       = 8;
  localparam int unsigned REG0_BIT    = 7;
  localparam int unsigned TYPE_HI     = 6;
  localparam int unsigned TYPE_LO     = 5;
  localparam logic [1:0]  TYPE_WRITE  = 2'h2;
  localparam logic [1:0]  TYPE_READ   = 2'h3;

  // Frame bit positions.
  localparam logic [CNT_W-1:0] CMD_PAR_IDX = 5'h0C;
  localparam logic [CNT_W-1:0] WR_DAT_LO   = 5'h0D;
  localparam logic [CNT_W-1:0] WR_DAT_HI   = 5'h14;
  localparam logic [CNT_W-1:0] WR_PAR_IDX  = 5'h15;
  localparam logic [CNT_W-1:0] RD_DAT_LO   = 5'h0E;
  localparam logic [CNT_W-1:0] RD_DAT_HI   = 5'h15;
  localparam logic [CNT_W-1:0] RD_PAR_IDX  = 5'h16;
  localparam logic [CNT_W-1:0] RD_PARK_IDX = 5'h17;
  localparam logic [CNT_W-1:0] CNT_MAX     = 5'h1F;

  // Control register fields.
  localparam int unsigned LOWPWR_BIT  = 7;
  localparam int unsigned STARTUP_BIT = 6;
  localparam int unsigned MASK_LO     = 3;
  localparam int unsigned TRIG_LO     = 0;

  // Reset values.
  localparam logic [DATA_W-1:0]   PATH_RST = 8'h00;
  localparam logic [NUM_TRIG-1:0] MASK_RST = 3'h0;
  localparam logic [SID_W-1:0]    SID_RST  = 4'hB;

endpackage

// File: sync_agree.sv
// Purpose: Three-flop synchroniser whose output moves once stages two and three agree.
// Assumes: Inputs come from another clock domain or a pin.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none
module sync_agree #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             ref_clk, // Sampling clock.
  input  wire logic             reset,   // Synchronous, active high.
  input  wire logic [WIDTH-1:0] din,     // Asynchronous input.
  output logic      [WIDTH-1:0] level    // Filtered level.
);

  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;

  always_ff @(posedge ref_clk) begin
    s1_r <= din;
    s2_r <= s1_r;
    s3_r <= s2_r;
  end

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge ref_clk) begin
      if (reset) begin
        level[i] <= 1'b0;
      end else if (s2_r[i] == s3_r[i]) begin
        level[i] <= s3_r[i];
      end
    end
  end

endmodule // sync_agree
`default_nettype wire

// File: rffe_switch_regs.sv
// Purpose: Serial-bus slave and register bank of an RF switch controller.
// Assumes: Link clock stands still between frames and runs only inside one.
// Notes:   Start sequences are caught on the system clock and clear the link receive and drive flops, not the readback mirrors.
`timescale 1ns/1ps
`default_nettype none
module rffe_switch_regs
  import rffe_switch_pkg::*;
#(
  parameter logic [DATA_W-1:0] PART_CODE   = 8'h5A, // Arbitrary value.
  parameter logic [DATA_W-1:0] MAKER_LOW   = 8'hA5, // Arbitrary value.
  parameter logic [1:0]        MAKER_HIGH  = 2'h1   // Arbitrary value.
) (
  input  wire logic              ref_clk,    // System clock, 100 MHz.
  input  wire logic              reset,      // Synchronous, active high.
  input  wire logic              linkClk,    // Bus clock from the master.
  input  wire logic              sdataIn,    // Bus data pin, input side.
  output logic                   sdataOut,   // Bus data pin, output side.
  output logic                   sdataOe,    // Bus data drive enable.
  output logic [DATA_W-1:0]      switchPath, // Active path-select value.
  output logic                   lowPower    // Low-power mode select.
);

  ////////////////////////////////////////////////////////////////////////////
  // Start sequence detection on the system clock.

  logic [1:0] pinLevel;
  logic       sclkS;
  logic       sdataS;
  logic       sdataLast_r;
  logic       startClr_r;

  sync_agree #(.WIDTH(2)) u_pinSync (
    .ref_clk (ref_clk),
    .reset   (reset),
    .din     ({linkClk, sdataIn}),
    .level   (pinLevel)
  );

  assign sclkS  = pinLevel[1];
  assign sdataS = pinLevel[0];

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sdataLast_r <= 1'b0;
    end else begin
      sdataLast_r <= sdataS;
    end
  end

  // Data only moves while the clock is low during a start sequence, so a
  // rising data edge with the clock low opens a frame. The clear is held
  // until data falls again, before the first clock edge of the frame.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      startClr_r <= 1'b1;
    end else if (!sclkS && sdataS && !sdataLast_r) begin
      startClr_r <= 1'b1;
    end else if (!sclkS && !sdataS && sdataLast_r) begin
      startClr_r <= 1'b0;
    end else if (sclkS) begin
      startClr_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register state on the system clock.

  logic [DATA_W-1:0]   pathDest_r;
  logic [DATA_W-1:0]   pathShadow_r;
  logic [NUM_TRIG-1:0] mask_r;
  logic                lowPower_r;
  logic [SID_W-1:0]    sid_r;

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: frame receive on the falling edge.

  logic [CNT_W-1:0]  cnt_r;
  logic [CMD_W-1:0]  cmd_r;
  logic [DATA_W-1:0] data_r;
  logic              wrArm_r;
  logic              readOk_r;
  logic              wrDone_r;
  logic [ADDR_W-1:0] wAddr_r;
  logic [DATA_W-1:0] wData_r;
  logic [SID_W-1:0]  sidM1_r;
  logic [SID_W-1:0]  sidM2_r;
  logic              cmdGood;

  assign cmdGood = (^{cmd_r, sdataIn}) &&
                   (cmd_r[SA_HI:SA_LO] == sidM2_r);

  always_ff @(negedge linkClk or posedge startClr_r) begin
    if (startClr_r) begin
      cnt_r    <= '0;
      cmd_r    <= '0;
      data_r   <= '0;
      wrArm_r  <= 1'b0;
      readOk_r <= 1'b0;
      wrDone_r <= 1'b0;
      wAddr_r  <= '0;
      wData_r  <= '0;
    end else begin
      if (cnt_r != CNT_MAX) begin
        cnt_r <= cnt_r + 5'h01;
      end
      if (cnt_r < CMD_PAR_IDX) begin
        cmd_r <= {cmd_r[CMD_W-2:0], sdataIn};
      end
      if (cnt_r == CMD_PAR_IDX && cmdGood) begin
        if (cmd_r[REG0_BIT]) begin
          wAddr_r  <= ADDR_PATH;
          wData_r  <= {1'b0, cmd_r[REG0_BIT-1:0]};
          wrDone_r <= 1'b1;
        end else if (cmd_r[TYPE_HI:TYPE_LO] == TYPE_WRITE) begin
          wrArm_r  <= 1'b1;
        end else if (cmd_r[TYPE_HI:TYPE_LO] == TYPE_READ) begin
          readOk_r <= 1'b1;
        end
      end
      if (wrArm_r && cnt_r >= WR_DAT_LO && cnt_r <= WR_DAT_HI) begin
        data_r <= {data_r[DATA_W-2:0], sdataIn};
      end
      if (wrArm_r && cnt_r == WR_PAR_IDX && (^{data_r, sdataIn})) begin
        wAddr_r  <= cmd_r[ADDR_W-1:0];
        wData_r  <= data_r;
        wrDone_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: readback mirrors and drive on the rising edge.

  // Register words only change after a write that ended a frame earlier, so
  // they are quiet whenever the link clock runs and two flops settle them.
  logic [DATA_W-1:0] pathM1_r;
  logic [DATA_W-1:0] pathM2_r;
  logic [DATA_W-1:0] ctrlM1_r;
  logic [DATA_W-1:0] ctrlM2_r;
  logic [DATA_W-1:0] ctrlWord;
  logic [DATA_W-1:0] rdWord;
  logic [2:0]        rdIdx;

  assign ctrlWord = {lowPower_r, 1'b0, mask_r, 3'h0};

  always_ff @(posedge linkClk) begin
    pathM1_r <= pathDest_r;
    pathM2_r <= pathM1_r;
    ctrlM1_r <= ctrlWord;
    ctrlM2_r <= ctrlM1_r;
    sidM1_r  <= sid_r;
    sidM2_r  <= sidM1_r;
  end

  always_comb begin
    case (cmd_r[ADDR_W-1:0])
      ADDR_PATH:   rdWord = pathM2_r;
      ADDR_CTRL:   rdWord = ctrlM2_r;
      ADDR_PART:   rdWord = PART_CODE;
      ADDR_MAKERL: rdWord = MAKER_LOW;
      ADDR_MAKERH: rdWord = {2'h0, MAKER_HIGH, sidM2_r};
      default:     rdWord = '0;
    endcase
  end

  assign rdIdx = 3'(RD_DAT_HI - cnt_r);

  always_ff @(posedge linkClk or posedge startClr_r) begin
    if (startClr_r) begin
      sdataOut <= 1'b0;
      sdataOe  <= 1'b0;
    end else if (readOk_r && cnt_r >= RD_DAT_LO && cnt_r <= RD_DAT_HI) begin
      sdataOut <= rdWord[rdIdx];
      sdataOe  <= 1'b1;
    end else if (readOk_r && cnt_r == RD_PAR_IDX) begin
      sdataOut <= ~(^rdWord);
      sdataOe  <= 1'b1;
    end else if (readOk_r && cnt_r == RD_PARK_IDX) begin
      sdataOut <= 1'b0;
      sdataOe  <= 1'b1;
    end else begin
      sdataOut <= 1'b0;
      sdataOe  <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write hand-over into the system domain.

  logic wrLevel;
  logic wrLast_r;
  logic wrStrobe;

  sync_agree #(.WIDTH(1)) u_wrSync (
    .ref_clk (ref_clk),
    .reset   (reset),
    .din     (wrDone_r),
    .level   (wrLevel)
  );

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wrLast_r <= 1'b0;
    end else begin
      wrLast_r <= wrLevel;
    end
  end

  // Address and data were settled before the level rose and hold until the
  // next start sequence, which is far later than this edge.
  assign wrStrobe = wrLevel && !wrLast_r;

  ////////////////////////////////////////////////////////////////////////////
  // Register updates.

  logic                wrPath;
  logic                wrCtrl;
  logic                startup;
  logic [NUM_TRIG-1:0] trigFire;

  assign wrPath  = wrStrobe && (wAddr_r == ADDR_PATH);
  assign wrCtrl  = wrStrobe && (wAddr_r == ADDR_CTRL);
  assign startup = wrCtrl && wData_r[STARTUP_BIT];

  for (genvar t = 0; t < NUM_TRIG; t++) begin : g_trig
    // A trigger loads only while its own mask is clear.
    assign trigFire[t] = wrCtrl && wData_r[TRIG_LO+t] && !mask_r[t];
  end

  always_ff @(posedge ref_clk) begin
    if (reset || startup) begin
      pathShadow_r <= PATH_RST;
    end else if (wrPath && !(&mask_r)) begin
      pathShadow_r <= wData_r;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset || startup) begin
      pathDest_r <= PATH_RST;
    end else if (wrPath && (&mask_r)) begin
      pathDest_r <= wData_r;
    end else if (|trigFire) begin
      pathDest_r <= pathShadow_r;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset || startup) begin
      mask_r     <= MASK_RST;
      lowPower_r <= 1'b0;
    end else if (wrCtrl) begin
      mask_r     <= wData_r[MASK_LO +: NUM_TRIG];
      lowPower_r <= wData_r[LOWPWR_BIT];
    end
  end

  // Writes to the maker-code low byte complete on the bus and change nothing.
  always_ff @(posedge ref_clk) begin
    if (reset || startup) begin
      sid_r <= SID_RST;
    end else if (wrStrobe && wAddr_r == ADDR_MAKERH) begin
      sid_r <= wData_r[SID_W-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      switchPath <= PATH_RST;
      lowPower   <= 1'b0;
    end else begin
      switchPath <= pathDest_r;
      lowPower   <= lowPower_r;
    end
  end

endmodule // rffe_switch_regs
`default_nettype wire

// File: rffe_switch_regs_sva.sv
// Purpose: Port checks for the switch register bank.
// Assumes: A read drives ten link bits.
// Notes:   Bound from the bench.
`timescale 1ns/1ps
`default_nettype none
module rffe_switch_regs_sva
  import rffe_switch_pkg::*;
(
  input wire logic              ref_clk,    // System clock.
  input wire logic              reset,      // Reset.
  input wire logic              linkClk,    // Link clock.
  input wire logic              sdataOut,   // Slave data.
  input wire logic              sdataOe,    // Slave enable.
  input wire logic [DATA_W-1:0] switchPath, // Path value.
  input wire logic              lowPower    // Low power.
);
  logic [9:0] rdSh; // Bits driven in the last read.
  always_ff @(negedge linkClk) if (sdataOe) rdSh <= {rdSh[8:0], sdataOut};
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////
  a_oe_window: assert property ($rose(sdataOe) |-> ##62 sdataOe ##[1:3] !sdataOe)
    else $error("read drive window wrong");
  a_oe_edge: assert property ($changed(sdataOe) |-> linkClk)
    else $error("enable moved off link edge");
  a_out_edge: assert property ($changed(sdataOut) |-> linkClk)
    else $error("data moved off link edge");
  a_out_quiet: assert property (!sdataOe |-> !sdataOut)
    else $error("data high while released");
  a_read_parity: assert property ($fell(sdataOe) |-> ^rdSh[9:1] && !rdSh[0])
    else $error("read parity or park wrong");
  a_path_idle: assert property ($changed(switchPath) |-> !sdataOe)
    else $error("path moved during read");
  a_power_idle: assert property ($changed(lowPower) |-> !sdataOe)
    else $error("power moved during read");
  a_reset_clear: assert property (disable iff (1'b0) reset ##1 reset |-> !switchPath && !lowPower)
    else $error("reset left state");
endmodule // rffe_switch_regs_sva
`default_nettype wire

// File: rffe_master.sv
// Purpose: Bus master model making the link clock and frames.
// Assumes: Slave samples on the falling link edge.
// Notes:   A released line flips every bit.
`timescale 1ns/1ps
`default_nettype none
module rffe_master (
  output logic      linkClk,  // Link clock.
  output wire logic sdataIn,  // Resolved line.
  input  wire logic sdataOut, // Slave data.
  input  wire logic sdataOe   // Slave enable.
);
  logic       d = 1'b0; // Master data.
  logic [9:0] q;        // Bits seen.
  initial linkClk = 1'b0;
  assign sdataIn = sdataOe ? sdataOut : d;
  task automatic bitx(input logic b);
    linkClk = 1'b1;
    d = b;
    #32 linkClk = 1'b0;
    q = {q[8:0], sdataIn};
    #32;
  endtask
  task automatic frame(input logic [11:0] c, input logic bp);
    #50.3 d = 1'b1;
    #50 d = 1'b0;
    #50;
    for (int i = 11; i >= 0; i--) bitx(c[i]);
    bitx(~^c ^ bp);
  endtask
  task automatic wr0(input logic [11:0] c, input logic bp);
    frame(c, bp);
    bitx(1'b0);
    #149.7;
  endtask
  task automatic wr(input logic [11:0] c, input logic [7:0] v, input logic bp);
    frame(c, 1'b0);
    for (int i = 7; i >= 0; i--) bitx(v[i]);
    bitx(~^v ^ bp);
    bitx(1'b0);
    #149.7;
  endtask
  task automatic rd(input logic [11:0] c);
    frame(c, 1'b0);
    bitx(1'b0);
    repeat (10) bitx(~d);
    linkClk = 1'b1;
    #32 linkClk = 1'b0;
    #149.7;
  endtask
endmodule // rffe_master
`default_nettype wire

// File: rffe_switch_control_registers_bench.sv
// Purpose: Self-checking bench for the switch register bank.
// Assumes: Register effects settle within the master's frame tail.
// Notes:   Seeded random data.
`timescale 1ns/1ps
`default_nettype none
module rffe_switch_control_registers_bench;
  import rffe_switch_pkg::*;
  logic              ref_clk;
  logic              reset;
  wire logic         linkClk, sdataIn, sdataOut, sdataOe, lowPower;
  wire logic [7:0]   switchPath;
  int                miscompares = 0, checks = 0, seed = 55829;
  logic [3:0]        sa = SID_RST;
  logic [7:0]        v, pth;
  rffe_switch_regs dut (.ref_clk(ref_clk), .reset(reset), .linkClk(linkClk), .sdataIn(sdataIn),
    .sdataOut(sdataOut), .sdataOe(sdataOe), .switchPath(switchPath), .lowPower(lowPower));
  rffe_master m (.linkClk(linkClk), .sdataIn(sdataIn), .sdataOut(sdataOut), .sdataOe(sdataOe));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    checks++;
    if (got !== exp) begin
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
      miscompares++;
    end
  endtask
  function automatic logic [11:0] cw(input logic [4:0] a);
    return {sa, 3'b010, a};
  endfunction
  task automatic rchk(input logic [4:0] a, input logic [7:0] x);
    m.rd({sa, 3'b011, a});
    chk(m.q, {x, ~^x, 1'b0});
  endtask
  task automatic wrap_up;
    if (miscompares == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    reset = 1'b1;
    repeat (4) @(negedge ref_clk);
    reset = 1'b0;
    repeat (6) @(negedge ref_clk);
    rchk(ADDR_PATH, PATH_RST);
    rchk(ADDR_CTRL, 8'h00);
    rchk(ADDR_PART, 8'h5A);
    rchk(ADDR_MAKERL, 8'hA5);
    rchk(ADDR_MAKERH, {4'h1, SID_RST});
    v = $random(seed);
    m.wr(cw({1'b0, v[3:0]} + 5'h01), v, 1'b0);
    rchk({1'b0, v[3:0]} + 5'h01, 8'h00);
    pth = PATH_RST;
    for (int t = 0; t < 3; t++) begin
      v = $random(seed);
      m.wr0({sa, 1'b1, v[6:0]}, 1'b0);
      chk(10'(switchPath), 10'(pth));
      m.wr(cw(ADDR_CTRL), 8'h00, 1'b0);
      chk(10'(switchPath), 10'(pth));
      m.wr(cw(ADDR_CTRL), 8'h01 << t, 1'b0);
      pth = {1'b0, v[6:0]};
      chk(10'(switchPath), 10'(pth));
    end
    m.wr(cw(ADDR_CTRL), 8'h38, 1'b0);
    rchk(ADDR_CTRL, 8'h38);
    v = $random(seed);
    m.wr(cw(ADDR_PATH), v, 1'b0);
    chk(10'(switchPath), 10'(v));
    rchk(ADDR_PATH, v);
    m.wr(cw(ADDR_PATH), ~v, 1'b1);
    m.wr0({sa, 1'b1, ~v[6:0]}, 1'b1);
    m.wr({~sa, 3'b010, ADDR_PATH}, ~v, 1'b0);
    chk(10'(switchPath), 10'(v));
    m.wr(cw(ADDR_MAKERL), 8'h00, 1'b0);
    m.wr(cw(ADDR_PART), 8'h00, 1'b0);
    rchk(ADDR_MAKERL, 8'hA5);
    rchk(ADDR_PART, 8'h5A);
    m.wr(cw(ADDR_CTRL), 8'hB8, 1'b0);
    chk(10'(lowPower), 10'h001);
    m.wr(cw(ADDR_MAKERH), 8'hF7, 1'b0);
    sa = 4'h7;
    #300;
    rchk(ADDR_MAKERH, 8'h17);
    m.wr(cw(ADDR_CTRL), 8'h40, 1'b0);
    sa = SID_RST;
    #300;
    chk(10'({lowPower, switchPath}), 10'h000);
    rchk(ADDR_CTRL, 8'h00);
    rchk(ADDR_MAKERH, {4'h1, SID_RST});
    wrap_up();
  end
endmodule // rffe_switch_control_registers_bench
bind rffe_switch_regs rffe_switch_regs_sva chk_i (.ref_clk(ref_clk), .reset(reset),
  .linkClk(linkClk), .sdataOut(sdataOut), .sdataOe(sdataOe), .switchPath(switchPath),
  .lowPower(lowPower));
`default_nettype wire
